//--- rtl/mlr_limit_bank.sv
// Limit register bank of the hardware monitor with comparators and interrupt.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// [RULE1] Flag value or temperature strictly above its high limit.
// [RULE2] Flag value or temperature equal to or below its low limit.
// [RULE3] A temperature one degree past a limit sets its status bit.
// [RULE4] Fan limit is 16 bits; count above it sets fan status bit.
// [RULE5] Voltage, temperature and fan limits stay writable when locked.
// [RULE6] Single-channel mode: fan-a high byte bits 7:5 select converter channel.
// [RULE7] Single-channel mode: bits 4:0 read-only reserved; else full limit byte.
// [RULE8] Temperature low limits reset to 0x81, high limits to 0x7F.
// [RULE9] Every fan limit byte resets to all ones.
// [RULE10] Voltage low limits reset to 0x00, high limits to 0xFF.
// [RULE11] Lock bit set makes pulse-output configuration registers read-only.
// [RULE12] No fan fault status while that fan's pulse output is off.
// [RULE13] Comparisons run whenever a new measurement is written.
module mlr_limit_bank
    import mlr_pkg::*;
(
    input  wire logic       CLK_SYS_I,
    input  wire logic       RESET_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    input  wire mlr_meas_s  MEAS_I,
    input  wire mlr_tach_s  TACH_I,
    output logic      [2:0] CHAN_SEL_O,
    output logic            SINGLE_MODE_O,
    output logic            IRQ_O
);

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] low_reg   [NUM_LIMIT_CH];
    logic [7:0] high_reg  [NUM_LIMIT_CH];
    logic [7:0] fan_lo_reg[NUM_FAN_CH];
    logic [7:0] fan_hi_reg[NUM_FAN_CH];
    logic [7:0] pwm_reg   [NUM_PWM];
    logic [7:0] cfg_a_reg;
    logic [7:0] cfg_b_reg;
    logic [7:0] lim_stat_reg;
    logic [7:0] fan_stat_reg;
    logic [7:0] lim_mask_reg;
    logic [7:0] fan_mask_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] lim_event;
    logic [7:0] fan_event;
    logic       locked;
    logic       single_mode;
    logic [15:0] fan_a_limit;

    assign locked      = cfg_a_reg[CFG_A_LOCK_BIT];
    assign single_mode = cfg_b_reg[CFG_B_SINGLE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Voltage channels 0..4 and temperature channels 5..7 share one layout:
    // low limit at even offset, high limit at the following odd offset.
    genvar g;
    generate
        for (g = 0; g < NUM_LIMIT_CH; g++) begin : g_lim
            localparam logic [7:0] LO_OFS =
                SUPPLY_A_LOW_LIMIT_OFS + 8'(2 * g);
            localparam logic [7:0] LO_RST =
                (g < 5) ? VOLT_LOW_RST : TEMP_LOW_RST;
            localparam logic [7:0] HI_RST =
                (g < 5) ? VOLT_HIGH_RST : TEMP_HIGH_RST;
            logic lo_hit;
            logic hi_hit;
            logic is_temp;

            assign is_temp = (g >= 5);

            always_ff @(posedge CLK_SYS_I) begin
                if (RESET_I) begin
                    low_reg[g]  <= LO_RST; // [RULE8] [RULE10]
                    high_reg[g] <= HI_RST; // [RULE8] [RULE10]
                end else if (WR_I) begin
                    // The lock bit is deliberately ignored here.
                    if (ADDR_I == LO_OFS) begin
                        low_reg[g] <= WDATA_I; // [RULE5]
                    end
                    if (ADDR_I == LO_OFS + 8'h01) begin
                        high_reg[g] <= WDATA_I; // [RULE5]
                    end
                end
            end

            // Temperatures are signed two's complement, voltages unsigned.
            always_comb begin
                if (is_temp) begin
                    hi_hit = $signed(MEAS_I.value) > $signed(high_reg[g]);
                    lo_hit = $signed(MEAS_I.value) <= $signed(low_reg[g]);
                end else begin
                    hi_hit = MEAS_I.value > high_reg[g]; // [RULE1]
                    lo_hit = MEAS_I.value <= low_reg[g]; // [RULE2]
                end
            end

            assign lim_event[g] = MEAS_I.valid && (MEAS_I.chan == 3'(g))
                                  && (hi_hit || lo_hit); // [RULE3] [RULE13]
        end

        for (g = 0; g < NUM_FAN_CH; g++) begin : g_fan
            localparam logic [7:0] LO_OFS =
                FAN_A_MIN_LOW_BYTE_OFS + 8'(2 * g);
            logic [15:0] limit;
            logic        pwm_off;

            always_ff @(posedge CLK_SYS_I) begin
                if (RESET_I) begin
                    fan_lo_reg[g] <= FAN_MIN_RST; // [RULE9]
                    fan_hi_reg[g] <= FAN_MIN_RST; // [RULE9]
                end else if (WR_I) begin
                    if (ADDR_I == LO_OFS) begin
                        fan_lo_reg[g] <= WDATA_I; // [RULE5]
                    end
                    if (ADDR_I == LO_OFS + 8'h01) begin
                        if (g == 0 && single_mode) begin
                            // Reserved low bits keep their value.
                            fan_hi_reg[g] <= {WDATA_I[7:CHAN_SEL_LSB],
                                fan_hi_reg[g][CHAN_SEL_LSB-1:0]}; // [RULE7]
                        end else begin
                            fan_hi_reg[g] <= WDATA_I; // [RULE5] [RULE7]
                        end
                    end
                end
            end

            assign limit = {fan_hi_reg[g], fan_lo_reg[g]};
            // Fan d shares pulse output c.
            assign pwm_off = pwm_reg[(g < NUM_PWM) ? g : NUM_PWM - 1]
                [7:PWM_BEHAVIOUR_LSB] == PWM_BEHAVIOUR_OFF;
            assign fan_event[g] = TACH_I.valid && (TACH_I.chan == 2'(g))
                && (TACH_I.count > limit) // [RULE4] [RULE13]
                && !pwm_off; // [RULE12]
        end

        for (g = 0; g < NUM_PWM; g++) begin : g_pwm
            always_ff @(posedge CLK_SYS_I) begin
                if (RESET_I) begin
                    pwm_reg[g] <= PWM_CFG_RST;
                end else if (WR_I && !locked
                             && ADDR_I == PULSE_OUT_A_CONFIG_OFS + 8'(g)) begin
                    pwm_reg[g] <= WDATA_I; // [RULE11]
                end
            end
        end
    endgenerate

    assign fan_event[7:NUM_FAN_CH] = '0;
    assign fan_a_limit = {fan_hi_reg[0], fan_lo_reg[0]};

    ////////////////////////////////////////////////////////////////////////////
    // Configuration. Lock is sticky until reset, so a stray write cannot
    // unlock the fan configuration.
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            cfg_a_reg <= ZERO_RST;
        end else if (WR_I && ADDR_I == CONFIG_A_OFS) begin
            cfg_a_reg <= WDATA_I | (cfg_a_reg & 8'h02); // [RULE11]
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            cfg_b_reg <= ZERO_RST;
        end else if (WR_I && ADDR_I == CONFIG_B_OFS) begin
            cfg_b_reg <= WDATA_I;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            lim_mask_reg <= ZERO_RST;
            fan_mask_reg <= ZERO_RST;
        end else if (WR_I) begin
            if (ADDR_I == LIMIT_MASK_OFS) begin
                lim_mask_reg <= WDATA_I;
            end
            if (ADDR_I == FAN_MASK_OFS) begin
                fan_mask_reg <= WDATA_I;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status, write one to clear; a new event wins over the clear.
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            lim_stat_reg <= ZERO_RST;
        end else begin
            lim_stat_reg <= (lim_stat_reg
                & ~((WR_I && ADDR_I == LIMIT_STATUS_OFS) ? WDATA_I : 8'h00))
                | lim_event; // [RULE1] [RULE2] [RULE3]
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            fan_stat_reg <= ZERO_RST;
        end else begin
            fan_stat_reg <= (fan_stat_reg
                & ~((WR_I && ADDR_I == FAN_STATUS_OFS) ? WDATA_I : 8'h00))
                | fan_event; // [RULE4]
        end
    end

    assign IRQ_O = |(lim_stat_reg & lim_mask_reg)
                 | |(fan_stat_reg & fan_mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        rdata_next = 8'h00;
        if (ADDR_I >= SUPPLY_A_LOW_LIMIT_OFS
            && ADDR_I <= REMOTE_B_TEMP_HIGH_LIMIT_OFS) begin
            rdata_next = ADDR_I[0]
                ? high_reg[3'((ADDR_I - SUPPLY_A_LOW_LIMIT_OFS) >> 1)]
                : low_reg[3'((ADDR_I - SUPPLY_A_LOW_LIMIT_OFS) >> 1)];
        end else if (ADDR_I >= FAN_A_MIN_LOW_BYTE_OFS
                     && ADDR_I <= FAN_D_MIN_HIGH_BYTE_OFS) begin
            rdata_next = ADDR_I[0]
                ? fan_hi_reg[2'((ADDR_I - FAN_A_MIN_LOW_BYTE_OFS) >> 1)]
                : fan_lo_reg[2'((ADDR_I - FAN_A_MIN_LOW_BYTE_OFS) >> 1)];
        end else if (ADDR_I >= PULSE_OUT_A_CONFIG_OFS
                     && ADDR_I <= PULSE_OUT_C_CONFIG_OFS) begin
            rdata_next = pwm_reg[2'(ADDR_I - PULSE_OUT_A_CONFIG_OFS)];
        end else if (ADDR_I == CONFIG_A_OFS) begin
            rdata_next = cfg_a_reg;
        end else if (ADDR_I == CONFIG_B_OFS) begin
            rdata_next = cfg_b_reg;
        end else if (ADDR_I == LIMIT_STATUS_OFS) begin
            rdata_next = lim_stat_reg;
        end else if (ADDR_I == FAN_STATUS_OFS) begin
            rdata_next = fan_stat_reg;
        end else if (ADDR_I == LIMIT_MASK_OFS) begin
            rdata_next = lim_mask_reg;
        end else if (ADDR_I == FAN_MASK_OFS) begin
            rdata_next = fan_mask_reg;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            rdata_reg <= ZERO_RST;
        end else if (RD_I) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= ZERO_RST;
        end
    end

    assign RDATA_O       = rdata_reg;
    assign CHAN_SEL_O    = fan_a_limit[15:13]; // [RULE6]
    assign SINGLE_MODE_O = single_mode; // [RULE6]

endmodule : mlr_limit_bank

`default_nettype wire

//--- rtl/mlr_pkg.sv
// Package for the monitor limit register bank: map, resets, carriers.
package mlr_pkg;

    // Limit and pulse-output configuration register offsets.
    localparam logic [7:0] SUPPLY_A_LOW_LIMIT_OFS       = 8'h44;
    localparam logic [7:0] SUPPLY_A_HIGH_LIMIT_OFS      = 8'h45;
    localparam logic [7:0] CORE_SUPPLY_LOW_LIMIT_OFS    = 8'h46;
    localparam logic [7:0] CORE_SUPPLY_HIGH_LIMIT_OFS   = 8'h47;
    localparam logic [7:0] MAIN_SUPPLY_LOW_LIMIT_OFS    = 8'h48;
    localparam logic [7:0] MAIN_SUPPLY_HIGH_LIMIT_OFS   = 8'h49;
    localparam logic [7:0] SUPPLY_B_LOW_LIMIT_OFS       = 8'h4A;
    localparam logic [7:0] SUPPLY_B_HIGH_LIMIT_OFS      = 8'h4B;
    localparam logic [7:0] SUPPLY_C_LOW_LIMIT_OFS       = 8'h4C;
    localparam logic [7:0] SUPPLY_C_HIGH_LIMIT_OFS      = 8'h4D;
    localparam logic [7:0] REMOTE_A_TEMP_LOW_LIMIT_OFS  = 8'h4E;
    localparam logic [7:0] REMOTE_A_TEMP_HIGH_LIMIT_OFS = 8'h4F;
    localparam logic [7:0] LOCAL_TEMP_LOW_LIMIT_OFS     = 8'h50;
    localparam logic [7:0] LOCAL_TEMP_HIGH_LIMIT_OFS    = 8'h51;
    localparam logic [7:0] REMOTE_B_TEMP_LOW_LIMIT_OFS  = 8'h52;
    localparam logic [7:0] REMOTE_B_TEMP_HIGH_LIMIT_OFS = 8'h53;
    localparam logic [7:0] FAN_A_MIN_LOW_BYTE_OFS       = 8'h54;
    localparam logic [7:0] FAN_A_MIN_HIGH_BYTE_OFS      = 8'h55;
    localparam logic [7:0] FAN_B_MIN_LOW_BYTE_OFS       = 8'h56;
    localparam logic [7:0] FAN_B_MIN_HIGH_BYTE_OFS      = 8'h57;
    localparam logic [7:0] FAN_C_MIN_LOW_BYTE_OFS       = 8'h58;
    localparam logic [7:0] FAN_C_MIN_HIGH_BYTE_OFS      = 8'h59;
    localparam logic [7:0] FAN_D_MIN_LOW_BYTE_OFS       = 8'h5A;
    localparam logic [7:0] FAN_D_MIN_HIGH_BYTE_OFS      = 8'h5B;
    localparam logic [7:0] PULSE_OUT_A_CONFIG_OFS       = 8'h5C;
    localparam logic [7:0] PULSE_OUT_B_CONFIG_OFS       = 8'h5D;
    localparam logic [7:0] PULSE_OUT_C_CONFIG_OFS       = 8'h5E;

    // Own control, status and mask registers.
    localparam logic [7:0] CONFIG_A_OFS      = 8'h40;
    localparam logic [7:0] LIMIT_STATUS_OFS  = 8'h41;
    localparam logic [7:0] FAN_STATUS_OFS    = 8'h42;
    localparam logic [7:0] CONFIG_B_OFS      = 8'h73;
    localparam logic [7:0] LIMIT_MASK_OFS    = 8'h74;
    localparam logic [7:0] FAN_MASK_OFS      = 8'h75;

    // Field positions.
    localparam int CFG_A_LOCK_BIT     = 1;
    localparam int CFG_B_SINGLE_BIT   = 6;
    localparam int CHAN_SEL_LSB       = 5;
    localparam int PWM_BEHAVIOUR_LSB  = 5;
    localparam logic [2:0] PWM_BEHAVIOUR_OFF = 3'h4;

    // Reset values.
    localparam logic [7:0] VOLT_LOW_RST  = 8'h00;
    localparam logic [7:0] VOLT_HIGH_RST = 8'hFF;
    localparam logic [7:0] TEMP_LOW_RST  = 8'h81;
    localparam logic [7:0] TEMP_HIGH_RST = 8'h7F;
    localparam logic [7:0] FAN_MIN_RST   = 8'hFF;
    localparam logic [7:0] PWM_CFG_RST   = 8'h82;
    localparam logic [7:0] ZERO_RST      = 8'h00;

    // Counts of channels.
    localparam int NUM_LIMIT_CH = 8;
    localparam int NUM_FAN_CH   = 4;
    localparam int NUM_PWM      = 3;

    // One new measurement for a voltage or temperature channel.
    typedef struct packed {
        logic       valid;
        logic [2:0] chan;
        logic [7:0] value;
    } mlr_meas_s;

    // One new tachometer count for a fan channel.
    typedef struct packed {
        logic        valid;
        logic [1:0]  chan;
        logic [15:0] count;
    } mlr_tach_s;

endpackage : mlr_pkg

//--- tb/mlr_host_model.sv
// Host software model that drives the register bus of the limit bank.
`timescale 1ns/1ps
`default_nettype none
module mlr_host_model
    import mlr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    initial begin
        addr_o  = 8'h00;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // Idle lines show the inverse of the last value, so that a slave
    // which samples them without a strobe cannot pass by luck.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        wr_o    <= 1'b1;
        addr_o  <= a;
        wdata_o <= v;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~v;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        rd_o   <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        #1;
        v = rdata_i;
    endtask : rd
endmodule : mlr_host_model
`default_nettype wire

//--- tb/mlr_limit_checker.sv
// Port assertions for the monitor limit register bank.
`timescale 1ns/1ps
`default_nettype none
module mlr_limit_checker
    import mlr_pkg::*;
(
    input wire logic       CLK_SYS_I,
    input wire logic       RESET_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    input wire mlr_meas_s  MEAS_I,
    input wire mlr_tach_s  TACH_I,
    input wire logic [2:0] CHAN_SEL_O,
    input wire logic       SINGLE_MODE_O,
    input wire logic       IRQ_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    sequence limit_wr_s;
        WR_I && ADDR_I inside {[8'h44:8'h54], [8'h56:8'h5B]};
    endsequence
    sequence same_rd_s;
        RD_I && ADDR_I == $past(ADDR_I, 2);
    endsequence
    read_back_a: assert property (
        limit_wr_s ##2 same_rd_s |=> RDATA_O == $past(WDATA_I, 3))
        else $error("limit read back wrong");
    rdata_idle_a: assert property (
        !$past(RD_I) |-> RDATA_O == 8'h00) else $error("rdata not idle");
    unmapped_rd_a: assert property (
        RD_I && ADDR_I inside {[8'h00:8'h3F]} |=> RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    chan_sel_wr_a: assert property (
        WR_I && ADDR_I == 8'h55 |=> CHAN_SEL_O == $past(WDATA_I[7:5]))
        else $error("channel select not written");
    chan_sel_hold_a: assert property (
        !(WR_I && ADDR_I == 8'h55) |=> $stable(CHAN_SEL_O))
        else $error("channel select moved");
    single_wr_a: assert property (
        WR_I && ADDR_I == 8'h73 |=> SINGLE_MODE_O == $past(WDATA_I[6]))
        else $error("single mode not written");
    irq_rise_a: assert property (
        $rose(IRQ_O) |-> $past(MEAS_I.valid) || $past(TACH_I.valid)
        || $past(WR_I)) else $error("irq rose without cause");
    irq_fall_a: assert property (
        $fell(IRQ_O) |-> $past(WR_I) || $past(RESET_I))
        else $error("irq fell without clear");
endmodule : mlr_limit_checker
////////////////////////////////////////////////////////////////////////////////
bind mlr_limit_bank mlr_limit_checker u_chk (.CLK_SYS_I(CLK_SYS_I),
    .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .MEAS_I(MEAS_I), .TACH_I(TACH_I),
    .CHAN_SEL_O(CHAN_SEL_O), .SINGLE_MODE_O(SINGLE_MODE_O), .IRQ_O(IRQ_O));
`default_nettype wire

//--- tb/mlr_limit_bank_tb.sv
// Self-checking bench for the monitor limit register bank.
`timescale 1ns/1ps
`default_nettype none
module mlr_limit_bank_tb
    import mlr_pkg::*;
;
    typedef struct packed {
        logic [7:0]  la;
        logic [15:0] lv;
        logic        fan;
        logic [2:0]  ch;
        logic [15:0] v;
        logic [7:0]  exp;
    } mlr_row_s;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr, wdata, rdata, d;
    logic       wr, rd, single, irq;
    logic [2:0] chan_sel;
    mlr_meas_s  meas = '0;
    mlr_tach_s  tach = '0;
    int         miscompares = 0;
    int         n_checks = 0;
    int         cycles = 0;
    // Row 5 (value 0x19 on channel 6) catches an unsigned temperature compare against the 0x81 low.
    mlr_row_s   rows [10] = '{
        '{8'h45, 16'h0080, 1'b0, 3'h0, 16'h0081, 8'h01},
        '{8'h45, 16'h0080, 1'b0, 3'h0, 16'h0080, 8'h00},
        '{8'h4C, 16'h0020, 1'b0, 3'h4, 16'h0020, 8'h10},
        '{8'h4C, 16'h0020, 1'b0, 3'h4, 16'h0021, 8'h00},
        '{8'h51, 16'h0019, 1'b0, 3'h6, 16'h001A, 8'h40},
        '{8'h51, 16'h0019, 1'b0, 3'h6, 16'h0019, 8'h00},
        '{8'h52, 16'h00F6, 1'b0, 3'h7, 16'h00F5, 8'h80},
        '{8'h56, 16'h1234, 1'b1, 3'h1, 16'h1235, 8'h02},
        '{8'h56, 16'h1234, 1'b1, 3'h1, 16'h1234, 8'h00},
        '{8'h5A, 16'h0100, 1'b1, 3'h3, 16'h0101, 8'h08}};

    mlr_limit_bank u_dut (.CLK_SYS_I(clk), .RESET_I(rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .MEAS_I(meas), .TACH_I(tach), .CHAN_SEL_O(chan_sel),
        .SINGLE_MODE_O(single), .IRQ_O(irq));
    mlr_host_model u_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            finish_test();
        end
    end
////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rst_val(input logic [7:0] a);
        if (a < 8'h4E) return a[0] ? 8'hFF : 8'h00;
        if (a < 8'h54) return a[0] ? 8'h7F : 8'h81;
        return (a < 8'h5C) ? 8'hFF : 8'h82;
    endfunction : rst_val

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic send(input logic f, input logic [2:0] c, input logic [15:0] v);
        @(posedge clk);
        if (f) tach <= {1'b1, c[1:0], v};
        else meas <= {1'b1, c, v[7:0]};
        @(posedge clk);
        tach.valid <= 1'b0;
        meas.valid <= 1'b0;
    endtask : send

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
    endtask : do_reset

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    initial begin
        do_reset();
        chk("chan_sel", 8'h07, {5'h00, chan_sel});
        chk("irq", 8'h00, {7'h00, irq});
        for (int i = 8'h44; i <= 8'h5E; i++) begin
            u_host.rd(i[7:0], d);
            chk("reset", rst_val(i[7:0]), d);
        end
        u_host.rd(8'h00, d);
        chk("unmapped", 8'h00, d);
        for (int i = 8'h5C; i <= 8'h5E; i++) u_host.wr(i[7:0], 8'h00);
        foreach (rows[i]) begin
            u_host.wr(8'h41, 8'hFF);
            u_host.wr(8'h42, 8'hFF);
            u_host.wr(rows[i].la, rows[i].lv[7:0]);
            if (rows[i].fan) u_host.wr(rows[i].la + 8'h01, rows[i].lv[15:8]);
            send(rows[i].fan, rows[i].ch, rows[i].v);
            u_host.rd(rows[i].fan ? 8'h42 : 8'h41, d);
            chk("status", rows[i].exp, d);
        end
        u_host.wr(8'h74, 8'h40);
        send(1'b0, 3'h6, 16'h001A);
        #1 chk("irq", 8'h01, {7'h00, irq});
        u_host.wr(8'h41, 8'h40);
        #1 chk("irq", 8'h00, {7'h00, irq});
        u_host.wr(8'h74, 8'h00);
        send(1'b0, 3'h6, 16'h001A);
        #1 chk("irq", 8'h00, {7'h00, irq});
        u_host.wr(8'h74, 8'h40);
        #1 chk("irq", 8'h01, {7'h00, irq});
        u_host.wr(8'h73, 8'h40);
        u_host.wr(8'h55, 8'hA0);
        #1 chk("single", 8'h01, {7'h00, single});
        chk("chan_sel", 8'h05, {5'h00, chan_sel});
        u_host.rd(8'h55, d);
        chk("fan_a_high", 8'hBF, d);
        u_host.wr(8'h73, 8'h00);
        u_host.wr(8'h55, 8'hA0);
        u_host.rd(8'h55, d);
        chk("fan_a_high", 8'hA0, d);
        u_host.wr(8'h40, 8'h02);
        for (int i = 8'h44; i <= 8'h5E; i++) begin
            u_host.wr(i[7:0], 8'h3C);
            u_host.rd(i[7:0], d);
            chk("locked", (i >= 8'h5C) ? 8'h00 : 8'h3C, d);
        end
        do_reset();
        chk("chan_sel", 8'h07, {5'h00, chan_sel});
        u_host.wr(8'h57, 8'h00);
        send(1'b1, 3'h1, 16'h0200);
        u_host.rd(8'h42, d);
        chk("fan_status", 8'h00, d);
        u_host.wr(8'h5D, 8'h00);
        send(1'b1, 3'h1, 16'h0200);
        u_host.rd(8'h42, d);
        chk("fan_status", 8'h02, d);
        finish_test();
    end
endmodule : mlr_limit_bank_tb
`default_nettype wire
